// ==== timer16_ctrl_status_irq.sv ====
// control, status and interrupt logic of a 16-bit capture/compare timer
// assumes pins arrive asynchronous to mclk and a strobe bus master on mclk
// Operation
// RULE1: one shared request, gated by enables and mask
// RULE2: enabled request wakes wait, never halt
// RULE3: capture enable passes either capture flag
// RULE4: compare enable passes either compare flag
// RULE5: overflow enable passes the overflow flag
// RULE6: force bit copies level b to pin b
// RULE7: force bit copies level a to pin a
// RULE8: level b on match b; pin a in pulse modes
// RULE9: capture a edge select, 1 rising
// RULE10: level a on match a to pin a
// RULE11: pin a enable only gates the pin
// RULE12: pin b enable only gates the pin
// RULE13: single pulse triggered by capture a edge
// RULE14: pwm: compare a width, compare b period
// RULE15: pwm wins over single pulse
// RULE16: clock select div4, div2, div8, external
// RULE17: no external pin: external select halts counter
// RULE18: capture b edge select, 1 rising
// RULE19: external clock edge select, 1 rising
// RULE20: status read only, low three bits zero
// RULE21: capture a flag, cleared by read then access
// RULE22: compare a flag, cleared by read then access
// RULE23: overflow flag on wrap, alternate low no clear
// RULE24: capture b flag, cleared by read then access
// RULE25: compare b flag, cleared by read then access
// RULE26: pwm never sets compare flags
// RULE27: request follows enabled flags while set
`timescale 1ns/1ns
module timer16_ctrl_status_irq #(
    parameter bit HAS_EXT_CLOCK = 1'b1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input timer16_pkg::bus_req_t bus_req,
    output logic [7:0] rdata,
    // cpu state
    input wire logic irq_mask,
    input wire logic wait_mode,
    input wire logic halt_mode,
    // pins
    input wire logic cap_a_pin,
    input wire logic cap_b_pin,
    input wire logic ext_clock_pin,
    output logic cmp_a_pin,
    output logic cmp_a_oe_n,
    output logic cmp_b_pin,
    output logic cmp_b_oe_n,
    // interrupt and wake
    output logic irq,
    output logic wake_req
);
    import timer16_pkg::*;

    logic [7:0] ctrl_one_reg;
    logic [7:0] ctrl_two_reg;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic cnt_moved_reg;
    logic [2:0] pre_reg;
    logic [15:0] cmp_a_reg;
    logic [15:0] cmp_b_reg;
    logic [15:0] cap_a_reg;
    logic [15:0] cap_b_reg;
    logic cmp_a_armed_reg;
    logic cmp_b_armed_reg;
    logic [2:0] sync_a_reg;
    logic [2:0] sync_b_reg;
    logic [2:0] sync_x_reg;
    logic [NUM_FLAGS-1:0] flag_reg;
    logic [NUM_FLAGS-1:0] seen_reg;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_access;
    logic cmp_a_pin_reg;
    logic cmp_b_pin_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    pin_mode_t mode;

    // bus strobes decoded by address
    wire wr = bus_req.wr;
    wire rd = bus_req.rd;
    wire acc = wr | rd;
    wire [3:0] adr = bus_req.addr;
    wire flags_read = rd && (adr == OFS_FLAGS);
    wire cnt_low_acc = acc && (adr == OFS_CNT_LOW);
    wire cnt_clear = wr && (adr == OFS_CNT_LOW || adr == OFS_ALT_CNT_LOW);

    // mode: pwm takes precedence when both mode bits are set
    always_comb
    begin
        if (ctrl_two_reg[C2_PWM])
            mode = MODE_PWM; // [RULE15]
        else if (ctrl_two_reg[C2_SINGLE])
            mode = MODE_SINGLE;
        else
            mode = MODE_COMPARE;
    end
    wire in_pwm = (mode == MODE_PWM);
    wire in_single = (mode == MODE_SINGLE);

    // edge detect reads only the second and third synchroniser stages
    wire cap_a_rise = sync_a_reg[1] & ~sync_a_reg[2];
    wire cap_a_fall = ~sync_a_reg[1] & sync_a_reg[2];
    wire cap_b_rise = sync_b_reg[1] & ~sync_b_reg[2];
    wire cap_b_fall = ~sync_b_reg[1] & sync_b_reg[2];
    wire ext_rise = sync_x_reg[1] & ~sync_x_reg[2];
    wire ext_fall = ~sync_x_reg[1] & sync_x_reg[2];
    wire cap_a_edge = ctrl_one_reg[C1_CAP_A_EDGE] ? cap_a_rise : cap_a_fall; // [RULE9]
    wire cap_b_edge = ctrl_two_reg[C2_CAP_B_EDGE] ? cap_b_rise : cap_b_fall; // [RULE18]
    wire ext_edge = ctrl_two_reg[C2_EXT_EDGE] ? ext_rise : ext_fall; // [RULE19]

    // capture a is disconnected in pwm and becomes the trigger in single pulse
    wire cap_a_hit = cap_a_edge && (mode == MODE_COMPARE);
    wire single_trig = cap_a_edge && in_single; // [RULE13]

    // counter tick source; a part without the pin stalls on the external code
    wire [1:0] clk_sel = ctrl_two_reg[C2_CLK_HI:C2_CLK_LO];
    logic tick;
    always_comb
    begin
        case (clk_sel) // [RULE16]
            CLK_DIV4: tick = ((pre_reg & PRE_MASK4) == PRE_MASK4);
            CLK_DIV2: tick = ((pre_reg & PRE_MASK2) == PRE_MASK2);
            CLK_DIV8: tick = ((pre_reg & PRE_MASK8) == PRE_MASK8);
            CLK_EXT: tick = HAS_EXT_CLOCK ? ext_edge : 1'b0; // [RULE17]
            default: tick = 1'b0;
        endcase
    end
    // halt freezes the count, wait does not
    wire advance = tick && !halt_mode;

    // compare matches are judged once per new count value; a high write disarms
    wire match_a = cnt_moved_reg && cmp_a_armed_reg && (cnt_reg == cmp_a_reg);
    wire match_b = cnt_moved_reg && cmp_b_armed_reg && (cnt_reg == cmp_b_reg);
    wire pwm_restart = match_b && in_pwm; // [RULE14]
    wire overflow = advance && (cnt_reg == CNT_TOP);

    // next counter value: software clear, pulse restarts, then counting
    always_comb
    begin
        if (cnt_clear || pwm_restart || single_trig)
            cnt_next = CNT_INIT;
        else if (advance)
            cnt_next = cnt_reg + 16'h0001;
        else
            cnt_next = cnt_reg;
    end

    // flag set sources; pwm and single pulse suppress some compare flags
    assign flag_set[F_CAP_A] = cap_a_hit || pwm_restart || single_trig; // [RULE21]
    assign flag_set[F_CMP_A] = match_a && (mode == MODE_COMPARE); // [RULE22] [RULE26]
    assign flag_set[F_OVF] = overflow; // [RULE23]
    assign flag_set[F_CAP_B] = cap_b_edge; // [RULE24]
    assign flag_set[F_CMP_B] = match_b && !in_pwm; // [RULE25] [RULE26]

    // second step of each clearing sequence: access to the matching low byte
    assign flag_access[F_CAP_A] = acc && (adr == OFS_CAP_A_LOW);
    assign flag_access[F_CMP_A] = acc && (adr == OFS_CMP_A_LOW);
    assign flag_access[F_OVF] = cnt_low_acc; // [RULE23]
    assign flag_access[F_CAP_B] = acc && (adr == OFS_CAP_B_LOW);
    assign flag_access[F_CMP_B] = acc && (adr == OFS_CMP_B_LOW);

    // per flag: a status read while set arms the clear; a new event beats it
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi = gi + 1)
        begin : g_flag
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                begin
                    flag_reg[gi] <= 1'b0;
                    seen_reg[gi] <= 1'b0;
                end
                else
                begin
                    if (flag_set[gi])
                        flag_reg[gi] <= 1'b1;
                    else if (flag_access[gi] && seen_reg[gi])
                        flag_reg[gi] <= 1'b0;
                    if (flag_access[gi])
                        seen_reg[gi] <= 1'b0;
                    else if (flags_read && flag_reg[gi])
                        seen_reg[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // control register writes
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctrl_one_reg <= CTRL_RESET;
            ctrl_two_reg <= CTRL_RESET;
        end
        else if (wr)
        begin
            if (adr == OFS_CTRL_ONE)
                ctrl_one_reg <= bus_req.wdata;
            if (adr == OFS_CTRL_TWO)
                ctrl_two_reg <= bus_req.wdata;
        end
    end

    // compare values; writing the high byte holds off matching until the low byte
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cmp_a_reg <= CMP_RESET;
            cmp_b_reg <= CMP_RESET;
            cmp_a_armed_reg <= 1'b1;
            cmp_b_armed_reg <= 1'b1;
        end
        else if (wr)
        begin
            case (adr)
                OFS_CMP_A_HIGH:
                begin
                    cmp_a_reg[15:8] <= bus_req.wdata;
                    cmp_a_armed_reg <= 1'b0;
                end
                OFS_CMP_A_LOW:
                begin
                    cmp_a_reg[7:0] <= bus_req.wdata;
                    cmp_a_armed_reg <= 1'b1;
                end
                OFS_CMP_B_HIGH:
                begin
                    cmp_b_reg[15:8] <= bus_req.wdata;
                    cmp_b_armed_reg <= 1'b0;
                end
                OFS_CMP_B_LOW:
                begin
                    cmp_b_reg[7:0] <= bus_req.wdata;
                    cmp_b_armed_reg <= 1'b1;
                end
                default:
                begin
                    cmp_a_armed_reg <= cmp_a_armed_reg;
                end
            endcase
        end
    end

    // counter, prescaler and capture registers
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cnt_reg <= CNT_INIT;
            cnt_moved_reg <= 1'b0;
            pre_reg <= 3'h0;
            cap_a_reg <= CAP_RESET;
            cap_b_reg <= CAP_RESET;
        end
        else
        begin
            cnt_reg <= cnt_next;
            cnt_moved_reg <= advance;
            pre_reg <= pre_reg + 3'h1;
            if (cap_a_hit)
                cap_a_reg <= cnt_reg;
            if (cap_b_edge)
                cap_b_reg <= cnt_reg;
        end
    end

    // pin synchronisers: stage 0 feeds only stage 1
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sync_a_reg <= 3'h0;
            sync_b_reg <= 3'h0;
            sync_x_reg <= 3'h0;
        end
        else
        begin
            sync_a_reg <= {sync_a_reg[1:0], cap_a_pin};
            sync_b_reg <= {sync_b_reg[1:0], cap_b_pin};
            sync_x_reg <= {sync_x_reg[1:0], ext_clock_pin};
        end
    end

    // compare output levels; the internal function runs whatever the pin enable
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cmp_a_pin_reg <= 1'b0;
            cmp_b_pin_reg <= 1'b0;
        end
        else
        begin
            if (mode != MODE_COMPARE && (pwm_restart || single_trig))
                cmp_a_pin_reg <= ctrl_one_reg[C1_LEVEL_B]; // [RULE8] [RULE13] [RULE14]
            else if (match_a || ctrl_one_reg[C1_FORCE_A])
                cmp_a_pin_reg <= ctrl_one_reg[C1_LEVEL_A]; // [RULE7] [RULE10]
            if ((match_b && mode == MODE_COMPARE) || ctrl_one_reg[C1_FORCE_B])
                cmp_b_pin_reg <= ctrl_one_reg[C1_LEVEL_B]; // [RULE6] [RULE8]
        end
    end
    // pin enables hand the pins over and nothing else
    assign cmp_a_pin = cmp_a_pin_reg;
    assign cmp_b_pin = cmp_b_pin_reg;
    assign cmp_a_oe_n = ~ctrl_two_reg[C2_PIN_A_EN]; // [RULE11]
    assign cmp_b_oe_n = ~ctrl_two_reg[C2_PIN_B_EN]; // [RULE12]

    // shared request: level, follows the enabled flags with no memory of its own
    wire cap_req = ctrl_one_reg[C1_CAP_IRQ] && (flag_reg[F_CAP_A] || flag_reg[F_CAP_B]); // [RULE3]
    wire cmp_req = ctrl_one_reg[C1_CMP_IRQ] && (flag_reg[F_CMP_A] || flag_reg[F_CMP_B]); // [RULE4]
    wire ovf_req = ctrl_one_reg[C1_OVF_IRQ] && flag_reg[F_OVF]; // [RULE5]
    wire any_req = cap_req || cmp_req || ovf_req; // [RULE27]
    assign irq = any_req && !irq_mask; // [RULE1]
    // halt stops the cpu clock tree, so only wait may be left on a timer event
    assign wake_req = any_req && wait_mode && !halt_mode; // [RULE2]

    // read data mux; status low bits and unmapped addresses read zero
    always_comb
    begin
        case (adr)
            OFS_CTRL_ONE: rdata_next = ctrl_one_reg;
            OFS_CTRL_TWO: rdata_next = ctrl_two_reg;
            OFS_FLAGS: rdata_next = {flag_reg, 3'h0}; // [RULE20]
            OFS_CAP_A_HIGH: rdata_next = cap_a_reg[15:8];
            OFS_CAP_A_LOW: rdata_next = cap_a_reg[7:0];
            OFS_CMP_A_HIGH: rdata_next = cmp_a_reg[15:8];
            OFS_CMP_A_LOW: rdata_next = cmp_a_reg[7:0];
            OFS_CNT_HIGH: rdata_next = cnt_reg[15:8];
            OFS_CNT_LOW: rdata_next = cnt_reg[7:0];
            OFS_ALT_CNT_HIGH: rdata_next = cnt_reg[15:8];
            OFS_ALT_CNT_LOW: rdata_next = cnt_reg[7:0];
            OFS_CAP_B_HIGH: rdata_next = cap_b_reg[15:8];
            OFS_CAP_B_LOW: rdata_next = cap_b_reg[7:0];
            OFS_CMP_B_HIGH: rdata_next = cmp_b_reg[15:8];
            OFS_CMP_B_LOW: rdata_next = cmp_b_reg[7:0];
            default: rdata_next = ZERO_BYTE;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rdata_reg <= ZERO_BYTE;
        else
            rdata_reg <= rd ? rdata_next : ZERO_BYTE;
    end
    assign rdata = rdata_reg;

endmodule

// ==== timer16_pkg.sv ====
// constants, register map and bus carrier for the 16-bit capture/compare timer
// assumes one cpu clock domain; the bus master is a plain strobe master
package timer16_pkg;

    // register offsets on the plain bus port
    localparam logic [3:0] OFS_CTRL_TWO = 4'h1;
    localparam logic [3:0] OFS_CTRL_ONE = 4'h2;
    localparam logic [3:0] OFS_FLAGS = 4'h3;
    localparam logic [3:0] OFS_CAP_A_HIGH = 4'h4;
    localparam logic [3:0] OFS_CAP_A_LOW = 4'h5;
    localparam logic [3:0] OFS_CMP_A_HIGH = 4'h6;
    localparam logic [3:0] OFS_CMP_A_LOW = 4'h7;
    localparam logic [3:0] OFS_CNT_HIGH = 4'h8;
    localparam logic [3:0] OFS_CNT_LOW = 4'h9;
    localparam logic [3:0] OFS_ALT_CNT_HIGH = 4'hA;
    localparam logic [3:0] OFS_ALT_CNT_LOW = 4'hB;
    localparam logic [3:0] OFS_CAP_B_HIGH = 4'hC;
    localparam logic [3:0] OFS_CAP_B_LOW = 4'hD;
    localparam logic [3:0] OFS_CMP_B_HIGH = 4'hE;
    localparam logic [3:0] OFS_CMP_B_LOW = 4'hF;

    // control one fields
    localparam int C1_CAP_IRQ = 7;
    localparam int C1_CMP_IRQ = 6;
    localparam int C1_OVF_IRQ = 5;
    localparam int C1_FORCE_B = 4;
    localparam int C1_FORCE_A = 3;
    localparam int C1_LEVEL_B = 2;
    localparam int C1_CAP_A_EDGE = 1;
    localparam int C1_LEVEL_A = 0;
    // control two fields
    localparam int C2_PIN_A_EN = 7;
    localparam int C2_PIN_B_EN = 6;
    localparam int C2_SINGLE = 5;
    localparam int C2_PWM = 4;
    localparam int C2_CLK_HI = 3;
    localparam int C2_CLK_LO = 2;
    localparam int C2_CAP_B_EDGE = 1;
    localparam int C2_EXT_EDGE = 0;

    // flag vector index; status bit is index plus FLAG_SHIFT
    localparam int FLAG_SHIFT = 3;
    localparam int F_CMP_B = 0;
    localparam int F_CAP_B = 1;
    localparam int F_OVF = 2;
    localparam int F_CMP_A = 3;
    localparam int F_CAP_A = 4;
    localparam int NUM_FLAGS = 5;

    // reset and load values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CNT_INIT = 16'hFFFC;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;
    localparam logic [15:0] CMP_RESET = 16'h8000;
    localparam logic [15:0] CAP_RESET = 16'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // clock select codes and prescaler masks
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    localparam logic [2:0] PRE_MASK4 = 3'h3;
    localparam logic [2:0] PRE_MASK2 = 3'h1;
    localparam logic [2:0] PRE_MASK8 = 3'h7;

    // output pin mode
    typedef enum logic [1:0] {MODE_COMPARE, MODE_SINGLE, MODE_PWM} pin_mode_t;

    // one bus request as the master drives it
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

endpackage

// ==== timer16_asserts.sv ====
// concurrent checks on the ports of the timer control, status and irq block
// bound into every instance of the design; one clock domain, sync reset
`timescale 1ns/1ns
module timer16_checker
    import timer16_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port and cpu state
    input wire timer16_pkg::bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire logic irq_mask,
    input wire logic wait_mode,
    input wire logic halt_mode,
    // compare pins and requests
    input wire logic cmp_a_pin,
    input wire logic cmp_a_oe_n,
    input wire logic cmp_b_pin,
    input wire logic cmp_b_oe_n,
    input wire logic irq,
    input wire logic wake_req
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // bus causes; a write lands one cycle later, a forced pin one more
    sequence flags_read;
        bus_req.rd && bus_req.addr == OFS_FLAGS;
    endsequence
    sequence ctrl_one_write;
        bus_req.wr && bus_req.addr == OFS_CTRL_ONE;
    endsequence
    sequence ctrl_two_write;
        bus_req.wr && bus_req.addr == OFS_CTRL_TWO;
    endsequence

    status_low_zero_a: assert property (flags_read |=> rdata[2:0] == 3'h0)
        else $error("status low bits not zero");
    mask_blocks_irq_a: assert property (irq_mask |-> !irq)
        else $error("irq raised while masked");
    halt_no_wake_a: assert property (halt_mode |-> !wake_req)
        else $error("wake request during halt");
    wake_follows_irq_a: assert property ((!irq_mask && wait_mode && !halt_mode) |-> wake_req == irq)
        else $error("wake request differs from irq in wait");
    irq_all_off_a: assert property ((ctrl_one_write ##0 bus_req.wdata[7:5] == 3'h0) |=> !irq)
        else $error("irq stays with all enables clear");
    pin_a_owner_a: assert property (ctrl_two_write |=> cmp_a_oe_n == !$past(bus_req.wdata[C2_PIN_A_EN]))
        else $error("pin a enable not followed");
    pin_b_owner_a: assert property (ctrl_two_write |=> cmp_b_oe_n == !$past(bus_req.wdata[C2_PIN_B_EN]))
        else $error("pin b enable not followed");
    force_a_level_a: assert property ((ctrl_one_write ##0 (bus_req.wdata[C1_FORCE_A] && !cmp_a_oe_n))
        |-> ##2 cmp_a_pin == $past(bus_req.wdata[C1_LEVEL_A], 2))
        else $error("forced level a not on pin");
    force_b_level_a: assert property ((ctrl_one_write ##0 (bus_req.wdata[C1_FORCE_B] && !cmp_b_oe_n))
        |-> ##2 cmp_b_pin == $past(bus_req.wdata[C1_LEVEL_B], 2))
        else $error("forced level b not on pin");
endmodule

bind timer16_ctrl_status_irq timer16_checker chk (
    .mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .irq_mask(irq_mask), .wait_mode(wait_mode), .halt_mode(halt_mode),
    .cmp_a_pin(cmp_a_pin), .cmp_a_oe_n(cmp_a_oe_n), .cmp_b_pin(cmp_b_pin),
    .cmp_b_oe_n(cmp_b_oe_n), .irq(irq), .wake_req(wake_req)
);

// ==== pin_partner.sv ====
// model of the pins outside the timer: capture sources and external clock
// driven by bench calls; every change lands just after a clock edge
`timescale 1ns/1ns
module pin_partner (
    // clock
    input wire logic mclk,
    // pins toward the timer
    output logic cap_a_pin,
    output logic cap_b_pin,
    output logic ext_clock_pin
);
    // pins idle low; the external clock stands still between bursts
    initial
    begin
        cap_a_pin = 1'b0;
        cap_b_pin = 1'b0;
        ext_clock_pin = 1'b0;
    end

    // levels held well past the three-flop synchroniser and edge detect
    task automatic set_caps(input logic a, input logic b);
        @(posedge mclk);
        cap_a_pin <= a;
        cap_b_pin <= b;
        repeat (8) @(posedge mclk);
    endtask

    // each level lasts several cycles so no edge is lost in sync
    task automatic ext_pulses(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            ext_clock_pin <= 1'b1;
            repeat (3) @(posedge mclk);
            ext_clock_pin <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the timer control, status and interrupt block
// one cpu clock; pins come from pin_partner, checker arrives by bind
`timescale 1ns/1ns
module testbench;
    import timer16_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    bus_req_t bus_req = '0;
    logic irq_mask = 1'b0;
    logic wait_mode = 1'b0;
    logic halt_mode = 1'b0;
    logic [7:0] rdata;
    logic cap_a_pin, cap_b_pin, ext_clock_pin;
    logic cmp_a_pin, cmp_a_oe_n, cmp_b_pin, cmp_b_oe_n, irq, wake_req;
    logic [7:0] d;
    logic p;
    int n;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    // 8 ns period
    always #4 mclk = ~mclk;
    pin_partner partner (.mclk(mclk), .cap_a_pin(cap_a_pin), .cap_b_pin(cap_b_pin),
        .ext_clock_pin(ext_clock_pin));
    timer16_ctrl_status_irq uut (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
        .irq_mask(irq_mask), .wait_mode(wait_mode), .halt_mode(halt_mode),
        .cap_a_pin(cap_a_pin), .cap_b_pin(cap_b_pin), .ext_clock_pin(ext_clock_pin),
        .cmp_a_pin(cmp_a_pin), .cmp_a_oe_n(cmp_a_oe_n), .cmp_b_pin(cmp_b_pin),
        .cmp_b_oe_n(cmp_b_oe_n), .irq(irq), .wake_req(wake_req));

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // bus accesses leave one idle cycle so no strobe is driven twice per step
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req <= '0;
        #1;
        d = rdata;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
        input string what);
        rd(a);
        check_byte(d & m, e, what);
    endtask
    task automatic set_cpu(input logic m, input logic w, input logic h);
        @(posedge mclk);
        irq_mask <= m;
        wait_mode <= w;
        halt_mode <= h;
        #1;
    endtask
    // status read arms the overflow clear; counter low write loads FFFC
    task automatic restart();
        rd(OFS_FLAGS);
        wr(OFS_CNT_LOW, 8'h00);
    endtask
    task automatic wait_irq();
        #1 n = 0;
        while (irq !== 1'b1 && n < 400)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask
    task automatic count_toggles(input int c);
        n = 0;
        #1 p = cmp_a_pin;
        repeat (c)
        begin
            @(posedge mclk);
            #1;
            if (cmp_a_pin !== p)
                n++;
            p = cmp_a_pin;
        end
    endtask

    task automatic test_regs();
        rd_chk(OFS_CTRL_ONE, 8'hFF, CTRL_RESET, "ctrl one reset");
        rd_chk(OFS_CTRL_TWO, 8'hFF, CTRL_RESET, "ctrl two reset");
        wr(OFS_FLAGS, 8'hFF);
        rd_chk(OFS_FLAGS, 8'hDF, 8'h00, "status read only");
        wr(4'h0, 8'hA5);
        rd_chk(4'h0, 8'hFF, 8'h00, "unmapped read");
        wr(OFS_CTRL_ONE, 8'h5A);
        rd_chk(OFS_CTRL_ONE, 8'hFF, 8'h5A, "ctrl one readback");
        wr(OFS_CTRL_ONE, 8'h00);
        $display("test_regs done");
    endtask

    task automatic test_overflow();
        wr(OFS_CTRL_ONE, 8'h20);
        restart();
        wait_irq();
        rd_chk(OFS_FLAGS, 8'hF8, 8'h20, "overflow flag");
        set_cpu(1'b0, 1'b1, 1'b0);
        check_byte({7'h00, wake_req}, 8'h01, "wake in wait");
        set_cpu(1'b0, 1'b1, 1'b1);
        check_byte({7'h00, wake_req}, 8'h00, "wake in halt");
        set_cpu(1'b1, 1'b0, 1'b0);
        check_byte({7'h00, irq}, 8'h00, "masked irq");
        set_cpu(1'b0, 1'b0, 1'b0);
        rd(OFS_ALT_CNT_LOW);
        rd_chk(OFS_FLAGS, 8'h20, 8'h20, "alt low keeps flag");
        rd(OFS_CNT_LOW);
        rd_chk(OFS_FLAGS, 8'h20, 8'h00, "overflow clear");
        check_byte({7'h00, irq}, 8'h00, "irq drops");
        $display("test_overflow done");
    endtask

    task automatic test_capture();
        logic lvl;
        logic act;
        lvl = 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            wr(OFS_CTRL_ONE, s[0] ? 8'h82 : 8'h80);
            wr(OFS_CTRL_TWO, s[0] ? 8'h02 : 8'h00);
            repeat (2)
            begin
                lvl = ~lvl;
                act = (lvl == s[0]);
                partner.set_caps(lvl, lvl);
                rd_chk(OFS_FLAGS, 8'h90, act ? 8'h90 : 8'h00, "capture flags");
                check_byte({7'h00, irq}, {7'h00, act}, "capture irq");
                rd(OFS_CAP_A_LOW);
                rd(OFS_FLAGS);
                rd(OFS_CAP_B_LOW);
                rd_chk(OFS_FLAGS, 8'h90, 8'h00, "capture clear");
            end
        end
        $display("test_capture done");
    endtask

    task automatic test_clock();
        int dv;
        wr(OFS_CTRL_ONE, 8'h20);
        for (int i = 0; i < 3; i++)
        begin
            dv = 2 << i;
            wr(OFS_CTRL_TWO, {4'h0, (i == 0) ? CLK_DIV2 : (i == 1) ? CLK_DIV4 : CLK_DIV8, 2'h0});
            restart();
            wait_irq();
            check_byte({7'h00, n >= 3 * dv && n <= 4 * dv + 2}, 8'h01, "prescale");
        end
        for (int e = 0; e < 2; e++)
        begin
            wr(OFS_CTRL_TWO, {4'h0, CLK_EXT, 1'b0, e[0]});
            restart();
            repeat (40) @(posedge mclk);
            check_byte({7'h00, irq}, 8'h00, "ext idle");
            partner.ext_pulses(4);
            repeat (4) @(posedge mclk);
            #1;
            check_byte({7'h00, irq}, 8'h01, "ext count");
        end
        wr(OFS_CTRL_ONE, 8'h00);
        $display("test_clock done");
    endtask

    task automatic clear_cmp();
        rd(OFS_CMP_A_LOW);
        rd(OFS_FLAGS);
        wr(OFS_CMP_B_LOW, 8'h04);
    endtask

    task automatic test_compare();
        wr(OFS_CMP_A_HIGH, 8'h00);
        wr(OFS_CMP_A_LOW, 8'h02);
        wr(OFS_CMP_B_HIGH, 8'h00);
        wr(OFS_CMP_B_LOW, 8'h04);
        wr(OFS_CTRL_ONE, 8'h45);
        wr(OFS_CTRL_TWO, 8'hC4);
        restart();
        repeat (40) @(posedge mclk);
        rd_chk(OFS_FLAGS, 8'h48, 8'h48, "compare flags");
        check_byte({4'h0, cmp_a_oe_n, cmp_b_oe_n, cmp_a_pin, cmp_b_pin}, 8'h03, "match pins");
        check_byte({7'h00, irq}, 8'h01, "compare irq");
        clear_cmp();
        rd_chk(OFS_FLAGS, 8'h48, 8'h00, "compare clear");
        check_byte({7'h00, irq}, 8'h00, "compare irq drops");
        wr(OFS_CTRL_ONE, 8'h18);
        repeat (3) @(posedge mclk);
        #1;
        check_byte({6'h00, cmp_a_pin, cmp_b_pin}, 8'h00, "forced pins");
        wr(OFS_CTRL_ONE, 8'h00);
        wr(OFS_CTRL_TWO, 8'h04);
        restart();
        repeat (40) @(posedge mclk);
        rd_chk(OFS_FLAGS, 8'h48, 8'h48, "match without pins");
        check_byte({6'h00, cmp_a_oe_n, cmp_b_oe_n}, 8'h03, "pins released");
        clear_cmp();
        $display("test_compare done");
    endtask

    task automatic test_pulse();
        wr(OFS_CTRL_ONE, 8'h04);
        wr(OFS_CMP_B_LOW, 8'h08);
        wr(OFS_CTRL_TWO, 8'hB4);
        restart();
        count_toggles(200);
        check_byte({7'h00, n >= 4}, 8'h01, "pwm waveform");
        rd_chk(OFS_FLAGS, 8'hC8, 8'h80, "pwm flags");
        wr(OFS_CTRL_TWO, 8'hA4);
        rd(OFS_FLAGS);
        rd(OFS_CAP_A_LOW);
        partner.set_caps(1'b1, cap_b_pin);
        count_toggles(40);
        check_byte(n[7:0], 8'h00, "no pulse on idle edge");
        partner.set_caps(1'b0, cap_b_pin);
        check_byte({7'h00, cmp_a_pin}, 8'h01, "pulse start");
        count_toggles(60);
        check_byte(n[7:0], 8'h01, "one pulse");
        rd_chk(OFS_FLAGS, 8'h80, 8'h80, "pulse capture flag");
        wr(OFS_CTRL_TWO, 8'h00);
        $display("test_pulse done");
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard; the run needs under a thousand cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            stop_test();
        end
    end

    // reset for 10 cycles, then the scenarios
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        test_regs();
        test_overflow();
        test_capture();
        test_clock();
        test_compare();
        test_pulse();
        stop_test();
    end
endmodule
